// ### coc_pkg.sv
// package of register map, field layouts and constants for the control block
package coc_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_RISE_EN_LO = 8'h08;
  localparam logic [7:0] OFS_RISE_EN_HI = 8'h0c;
  localparam logic [7:0] OFS_RISE_MODE_LO = 8'h10;
  localparam logic [7:0] OFS_RISE_MODE_HI = 8'h14;
  localparam logic [7:0] OFS_UP_DB_COUNT = 8'h18;
  localparam logic [7:0] OFS_DOWN_DB_COUNT = 8'h1c;
  localparam logic [7:0] OFS_BUF_STATUS = 8'h20;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  // clock selection codes
  localparam logic [1:0] CS_DIV4 = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_FAST_OSC = 2'h2;
  // divide-by-four terminal count
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // number of event sources
  localparam int N_SRC = 16;
  // output modes
  typedef enum logic [2:0] {
    MODE_STEERED = 3'b000,
    MODE_SYNC_STEERED = 3'b001,
    MODE_FWD_FULL = 3'b010,
    MODE_REV_FULL = 3'b011,
    MODE_HALF = 3'b100,
    MODE_PUSH_PULL = 3'b101,
    MODE_RSVD = 3'b110
  } coc_mode_e;
  // control_0 layout: bit7 enable, bit6 load, bit5 zero, 4:3 clk, 2:0 mode
  typedef struct packed {
    logic en;
    logic load_request;
    logic unused;
    logic [1:0] clk_sel;
    logic [2:0] mode_select;
  } coc_ctrl0_s;
  // control_1 layout: bit7 up source, bit6 down source, 3:0 inverts
  typedef struct packed {
    logic up_deadband_source;
    logic down_deadband_source;
    logic [1:0] unused;
    logic out_d_invert;
    logic out_c_invert;
    logic out_b_invert;
    logic out_a_invert;
  } coc_ctrl1_s;
endpackage

// ### coc_ctrl.sv
// control, configuration and rising-event selection of the output generator
`timescale 1ns/1ps
`default_nettype none
module coc_ctrl
  import coc_pkg::*;
#(
  parameter int CNT_W = 6
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source from the internal fast oscillator
  input wire logic internal_fast_oscillator,
  // event sources: 0 pin, 1-4 comparators, 5-6 capture, 7-10 pwm,
  // 11 modulator, 12-15 logic cells
  input wire logic [N_SRC-1:0] event_src,
  // active-high waveforms from the generator core
  input wire logic [3:0] core_drive,
  // generator controls
  output logic gen_enable,
  output logic gen_tick,
  output logic fast_osc_request,
  output coc_mode_e mode_sel,
  // dead-band timing
  output logic up_db_use_chain,
  output logic down_db_use_chain,
  output logic up_db_tick,
  output logic down_db_tick,
  output logic [CNT_W-1:0] up_db_buf,
  output logic [CNT_W-1:0] down_db_buf,
  // rising events
  output logic rise_edge_event,
  output logic rise_level_event,
  // polarity-corrected pins
  output logic drive_out_a,
  output logic drive_out_b,
  output logic drive_out_c,
  output logic drive_out_d
);
  // mode field decode, reserved codes map to a safe idle value
  function automatic coc_mode_e decode_mode(input logic [2:0] m);
    case (m)
      3'b000: decode_mode = MODE_STEERED;
      3'b001: decode_mode = MODE_SYNC_STEERED;
      3'b010: decode_mode = MODE_FWD_FULL;
      3'b011: decode_mode = MODE_REV_FULL;
      3'b100: decode_mode = MODE_HALF;
      3'b101: decode_mode = MODE_PUSH_PULL;
      default: decode_mode = MODE_RSVD;
    endcase
  endfunction
  // register state
  coc_ctrl0_s ctrl0_q; // control_0 fields
  coc_ctrl1_s ctrl1_q; // control_1 fields
  logic [N_SRC-1:0] up_event_source_mask_q; // rising source enables
  logic [N_SRC-1:0] up_event_edge_mode_q; // rising edge modes
  logic [CNT_W-1:0] up_cnt_q; // up dead-band count register
  logic [CNT_W-1:0] down_cnt_q; // down dead-band count register
  logic [CNT_W-1:0] up_buf_q; // up working buffer
  logic [CNT_W-1:0] down_buf_q; // down working buffer
  // bus state
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // generator state
  logic [1:0] div_q; // divide-by-four counter
  logic tick_q; // generator clock enable
  logic [N_SRC-1:0] src_prev_q; // source levels at previous tick
  logic edge_evt_q; // delayed-path event
  logic level_evt_q; // immediate event
  logic [3:0] drive_q; // output pins
  // combinational helpers
  logic wr_acc; // write takes effect
  logic addr_ok; // address decodes
  logic tick_d;
  logic [N_SRC-1:0] edge_hit;
  logic [N_SRC-1:0] level_hit;
  logic any_event;
  logic transfer; // buffers loaded this cycle
  logic [31:0] rd_d;
  // write completes at the access edge with pready high
  assign wr_acc = psel && penable && pready_q && pwrite;

  // read mux and address decode, unused bits stay zero
  always_comb begin
    rd_d = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      OFS_CONTROL_0: begin
        rd_d[7:0] = {ctrl0_q.en, ctrl0_q.load_request, 1'b0,
                     ctrl0_q.clk_sel, ctrl0_q.mode_select};
      end
      OFS_CONTROL_1: begin
        rd_d[7:0] = {ctrl1_q[7:6], 2'h0, ctrl1_q[3:0]};
      end
      OFS_RISE_EN_LO: rd_d[7:0] = up_event_source_mask_q[7:0];
      OFS_RISE_EN_HI: rd_d[7:0] = up_event_source_mask_q[15:8];
      OFS_RISE_MODE_LO: rd_d[7:0] = up_event_edge_mode_q[7:0];
      OFS_RISE_MODE_HI: rd_d[7:0] = up_event_edge_mode_q[15:8];
      OFS_UP_DB_COUNT: rd_d[CNT_W-1:0] = up_cnt_q;
      OFS_DOWN_DB_COUNT: rd_d[CNT_W-1:0] = down_cnt_q;
      OFS_BUF_STATUS: begin
        rd_d[CNT_W-1:0] = up_buf_q;
        rd_d[CNT_W+7:8] = down_buf_q;
      end
      default: addr_ok = 1'b0; // unmapped word, data stays zero
    endcase
  end

  // apb answer: ready one cycle after setup, data and error with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      prdata_q <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
      pslverr_q <= psel && !penable && !addr_ok;
    end
  end

  // control_0 in one process, so the word has a single driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= RST_BYTE;
    end else begin
      if (wr_acc && paddr == OFS_CONTROL_0) begin
        ctrl0_q.en <= pwdata[7];
        ctrl0_q.clk_sel <= pwdata[4:3];
        ctrl0_q.mode_select <= pwdata[2:0];
      end
      // load request: software sets, hardware clears, set wins
      if (wr_acc && paddr == OFS_CONTROL_0 && pwdata[6]) begin
        ctrl0_q.load_request <= 1'b1;
      end else if (transfer || !ctrl0_q.en) begin
        ctrl0_q.load_request <= 1'b0;
      end
    end
  end

  // control_1 register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= RST_BYTE;
    end else if (wr_acc && paddr == OFS_CONTROL_1) begin
      ctrl1_q <= {pwdata[7:6], 2'h0, pwdata[3:0]};
    end
  end

  // rising source enable and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_event_source_mask_q <= RST_HALF;
      up_event_edge_mode_q <= RST_HALF;
    end else if (wr_acc) begin
      case (paddr)
        OFS_RISE_EN_LO: up_event_source_mask_q[7:0] <= pwdata[7:0];
        OFS_RISE_EN_HI: up_event_source_mask_q[15:8] <= pwdata[7:0];
        OFS_RISE_MODE_LO: up_event_edge_mode_q[7:0] <= pwdata[7:0];
        OFS_RISE_MODE_HI: up_event_edge_mode_q[15:8] <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // dead-band count registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_q <= '0;
      down_cnt_q <= '0;
    end else if (wr_acc && paddr == OFS_UP_DB_COUNT) begin
      up_cnt_q <= pwdata[CNT_W-1:0];
    end else if (wr_acc && paddr == OFS_DOWN_DB_COUNT) begin
      down_cnt_q <= pwdata[CNT_W-1:0];
    end
  end

  // buffer transfer on the first event after a load request
  assign transfer = ctrl0_q.en && ctrl0_q.load_request && any_event;
  // working buffers follow counts while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_buf_q <= '0;
      down_buf_q <= '0;
    end else if (!ctrl0_q.en || transfer) begin
      up_buf_q <= up_cnt_q;
      down_buf_q <= down_cnt_q;
    end
  end

  // generator clock enable from the selected source
  always_comb begin
    case (ctrl0_q.clk_sel)
      CS_DIV4: tick_d = div_q == DIV4_LAST;
      CS_SYS: tick_d = 1'b1;
      CS_FAST_OSC: tick_d = internal_fast_oscillator;
      default: tick_d = 1'b0;
    endcase
  end

  // divider and tick register, stopped while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end else if (!ctrl0_q.en) begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      tick_q <= tick_d;
    end
  end

  // per-source event qualification
  assign edge_hit = up_event_source_mask_q & up_event_edge_mode_q &
                    event_src & ~src_prev_q;
  assign level_hit = up_event_source_mask_q & ~up_event_edge_mode_q &
                     event_src;
  assign any_event = edge_evt_q || level_evt_q;
  // source history sampled on generator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= RST_HALF;
    end else if (tick_q) begin
      src_prev_q <= event_src;
    end
  end

  // rising events, edges on ticks, levels at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_evt_q <= 1'b0;
      level_evt_q <= 1'b0;
    end else begin
      edge_evt_q <= ctrl0_q.en && tick_q && (|edge_hit);
      level_evt_q <= ctrl0_q.en && (|level_hit);
    end
  end

  // output pins: inactive level while off, polarity applied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 4'h0;
    end else begin
      drive_q <= (ctrl0_q.en ? core_drive : 4'h0) ^
                 ctrl1_q[3:0];
    end
  end

  // registered generator controls
  logic up_tick_q;
  logic down_tick_q;
  logic osc_req_q;
  coc_mode_e mode_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_tick_q <= 1'b0;
      down_tick_q <= 1'b0;
      osc_req_q <= 1'b0;
      mode_q <= MODE_STEERED;
    end else begin
      up_tick_q <= tick_d && ctrl0_q.en &&
                   !ctrl1_q.up_deadband_source;
      down_tick_q <= tick_d && ctrl0_q.en &&
                     !ctrl1_q.down_deadband_source;
      osc_req_q <= ctrl0_q.en && ctrl0_q.clk_sel == CS_FAST_OSC;
      mode_q <= decode_mode(ctrl0_q.mode_select);
    end
  end

  // output wiring, all from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gen_enable = ctrl0_q.en;
  assign gen_tick = tick_q;
  assign fast_osc_request = osc_req_q;
  assign mode_sel = mode_q;
  assign up_db_use_chain = ctrl1_q.up_deadband_source;
  assign down_db_use_chain = ctrl1_q.down_deadband_source;
  assign up_db_tick = up_tick_q;
  assign down_db_tick = down_tick_q;
  assign up_db_buf = up_buf_q;
  assign down_db_buf = down_buf_q;
  assign rise_edge_event = edge_evt_q;
  assign rise_level_event = level_evt_q;
  assign drive_out_a = drive_q[0];
  assign drive_out_b = drive_q[1];
  assign drive_out_c = drive_q[2];
  assign drive_out_d = drive_q[3];

  // checks
  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
      !ctrl0_q.en |=> !tick_q && !edge_evt_q && !level_evt_q;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("events while disabled");
  property p_load_clears;
    @(posedge pclk) disable iff (!presetn)
      transfer && !(wr_acc && paddr == OFS_CONTROL_0 && pwdata[6])
      |=> !ctrl0_q.load_request && up_buf_q == $past(up_cnt_q);
  endproperty
  a_load_clears: assert property (p_load_clears)
    else $error("load request not cleared after transfer");
  property p_hold_while_pending;
    @(posedge pclk) disable iff (!presetn)
      ctrl0_q.en && $past(ctrl0_q.en) && !$past(transfer)
      |-> $stable(up_buf_q);
  endproperty
  a_hold_while_pending: assert property (p_hold_while_pending)
    else $error("buffer changed without transfer");
  // the tick must come from the divider, not the rate selected before
  property p_div4;
    @(posedge pclk) disable iff (!presetn)
      ctrl0_q.en && ctrl0_q.clk_sel == CS_DIV4 && tick_q &&
      $past(ctrl0_q.clk_sel) == CS_DIV4 |=> !tick_q [*3];
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by four tick spacing wrong");
  property p_mode_map;
    @(posedge pclk) disable iff (!presetn)
      ctrl0_q.mode_select == 3'b101 |=> mode_q == MODE_PUSH_PULL ||
        $past(ctrl0_q.mode_select) != ctrl0_q.mode_select;
  endproperty
  a_mode_map: assert property (p_mode_map)
    else $error("push-pull decode wrong");
  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      !ctrl0_q.en |=> drive_q == $past(ctrl1_q[3:0]);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("inactive level ignores polarity");
  property p_masked_none;
    @(posedge pclk) disable iff (!presetn)
      up_event_source_mask_q == RST_HALF |=> !level_evt_q && !edge_evt_q;
  endproperty
  a_masked_none: assert property (p_masked_none)
    else $error("event from disabled source");
  property p_level_now;
    @(posedge pclk) disable iff (!presetn)
      ctrl0_q.en && (|level_hit) |=> level_evt_q;
  endproperty
  a_level_now: assert property (p_level_now)
    else $error("level event late");
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      pready_q && !pwrite && paddr == OFS_CONTROL_1 |-> prdata_q[5:4] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented bits read nonzero");
  property p_direct_load;
    @(posedge pclk) disable iff (!presetn)
      !ctrl0_q.en ##1 !ctrl0_q.en |-> up_buf_q == $past(up_cnt_q);
  endproperty
  a_direct_load: assert property (p_direct_load)
    else $error("disabled buffer not following count");
  c_transfer: cover property (@(posedge pclk) disable iff (!presetn) transfer);
  c_edge: cover property (@(posedge pclk) disable iff (!presetn) edge_evt_q);
  c_osc: cover property (@(posedge pclk) disable iff (!presetn)
    osc_req_q ##1 tick_q);

endmodule
`default_nettype wire

// ### coc_switch_model.sv
// behavioural model of the power switch driver stage on the output pins
`timescale 1ns/1ps
`default_nettype none
module coc_switch_model (
  // pins from the generator
  input wire logic drive_out_a,
  input wire logic drive_out_b,
  input wire logic drive_out_c,
  input wire logic drive_out_d,
  // gate levels seen by the switches, bit0 = a
  output logic [3:0] gate_level
);
  // switch gates follow the pin levels with no extra inversion
  assign gate_level = {drive_out_d, drive_out_c, drive_out_b, drive_out_a};
endmodule
`default_nettype wire

// ### test_coc_ctrl.sv
// self-checking testbench for the output generator control block
`timescale 1ns/1ps
`default_nettype none
module test_coc_ctrl;
  import coc_pkg::*;
  // clock, reset and apb
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  // generator side
  logic osc, gen_enable, gen_tick, fast_osc_request;
  logic up_chain, down_chain, up_db_tick, down_db_tick;
  logic rise_edge_event, rise_level_event;
  logic pa, pb, pc, pd;
  logic [15:0] event_src;
  logic [3:0] core_drive, gate;
  logic [5:0] up_buf, down_buf;
  coc_mode_e mode_sel;
  logic e;
  int bad_count = 0;
  int check_count = 0;
  int c;
  // free-running 100 MHz clock
  always #5 pclk = ~pclk;
  coc_ctrl #(.CNT_W(6)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_fast_oscillator(osc), .event_src(event_src),
    .core_drive(core_drive), .gen_enable(gen_enable), .gen_tick(gen_tick),
    .fast_osc_request(fast_osc_request), .mode_sel(mode_sel),
    .up_db_use_chain(up_chain), .down_db_use_chain(down_chain),
    .up_db_tick(up_db_tick), .down_db_tick(down_db_tick),
    .up_db_buf(up_buf), .down_db_buf(down_buf),
    .rise_edge_event(rise_edge_event), .rise_level_event(rise_level_event),
    .drive_out_a(pa), .drive_out_b(pb), .drive_out_c(pc), .drive_out_d(pd));
  // far-side driver stage
  coc_switch_model model_u (.drive_out_a(pa), .drive_out_b(pb),
    .drive_out_c(pc), .drive_out_d(pd), .gate_level(gate));
  // verdict and end of run
  task results();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // compare one value
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        bad_count++;
        results();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask
  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, d, e);
    check(name, d, exp);
  endtask
  // select one observed pulse or level
  function automatic logic pick(input int k);
    case (k)
      0: return gen_tick;
      1: return rise_level_event;
      2: return rise_edge_event;
      3: return up_db_tick;
      default: return down_db_tick;
    endcase
  endfunction
  // count cycles in which the chosen signal is high
  task cnt(input int k, input int n);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pick(k) === 1'b1) c++;
    end
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc = 1'b0;
    event_src = 16'h0000;
    core_drive = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of every register, then an unmapped word
    for (int i = 0; i <= 8; i++) begin
      rdc("reset value", 8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0, d, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    // unimplemented bit and load request read zero while disabled
    wr(OFS_CONTROL_0, 32'h75);
    rdc("ctrl0 readback", OFS_CONTROL_0, 32'h15);
    // every legal mode code
    // reserved mode codes 11x and clock code 11 are never written
    for (int m = 0; m < 6; m++) begin
      wr(OFS_CONTROL_0, 32'(m));
      repeat (2) @(posedge pclk);
      check("mode", {29'h0, mode_sel}, 32'(m));
    end
    wr(OFS_CONTROL_1, 32'hff);
    rdc("ctrl1 readback", OFS_CONTROL_1, 32'hcf);
    check("up chain", {31'h0, up_chain}, 32'h1);
    check("down chain", {31'h0, down_chain}, 32'h1);
    // counts go straight to buffers while disabled
    wr(OFS_UP_DB_COUNT, 32'h15);
    wr(OFS_DOWN_DB_COUNT, 32'h0a);
    rdc("direct load", OFS_BUF_STATUS, 32'h0a15);
    // polarity: a and b inverted, enabled, clock every cycle
    wr(OFS_CONTROL_1, 32'h03);
    core_drive <= 4'h5;
    wr(OFS_CONTROL_0, 32'h88);
    repeat (3) @(posedge pclk);
    check("pins enabled", {28'h0, gate}, 32'h6);
    check("gen enable", {31'h0, gen_enable}, 32'h1);
    cnt(3, 16);
    check("up db ticks", 32'(c != 0), 32'h1);
    cnt(4, 16);
    check("down db ticks", 32'(c != 0), 32'h1);
    // delay chain on the up side: no generator clock ticks for it
    wr(OFS_CONTROL_1, 32'h83);
    @(posedge pclk);
    cnt(3, 16);
    check("up db chain ticks", 32'(c), 32'h0);
    wr(OFS_CONTROL_1, 32'h03);
    // generator clock rates per selection, one edge to drop old rate
    wr(OFS_CONTROL_0, 32'h80);
    @(posedge pclk);
    cnt(0, 16);
    check("div4 ticks", 32'(c), 32'h4);
    wr(OFS_CONTROL_0, 32'h90);
    @(posedge pclk);
    cnt(0, 16);
    check("fast osc idle ticks", 32'(c), 32'h0);
    check("osc request", {31'h0, fast_osc_request}, 32'h1);
    // oscillator running: ticks follow it one cycle late
    osc <= 1'b1;
    cnt(0, 8);
    check("fast osc ticks", 32'(c), 32'h7);
    osc <= 1'b0;
    wr(OFS_CONTROL_0, 32'h88);
    @(posedge pclk);
    cnt(0, 16);
    check("sys ticks", 32'(c), 32'h10);
    // source 0 enabled in level mode, source 1 left out
    wr(OFS_RISE_EN_LO, 32'h01);
    event_src <= 16'h0002;
    cnt(1, 8);
    check("masked source", 32'(c), 32'h0);
    event_src <= 16'h0001;
    cnt(1, 8);
    check("level event", 32'(c != 0), 32'h1);
    event_src <= 16'h0000;
    wr(OFS_RISE_MODE_LO, 32'h01);
    event_src <= 16'h0001;
    cnt(2, 8);
    check("edge event once", 32'(c), 32'h1);
    // highest source alone in level mode
    wr(OFS_RISE_EN_LO, 32'h00);
    wr(OFS_RISE_EN_HI, 32'h80);
    event_src <= 16'h8000;
    cnt(1, 8);
    check("source 15 level", 32'(c != 0), 32'h1);
    // buffered load waits for request and event
    event_src <= 16'h0000;
    wr(OFS_UP_DB_COUNT, 32'h2a);
    rdc("held buffer", OFS_BUF_STATUS, 32'h0a15);
    wr(OFS_CONTROL_0, 32'hc8);
    rdc("load pending", OFS_CONTROL_0, 32'hc8);
    event_src <= 16'h8000;
    repeat (4) @(posedge pclk);
    rdc("loaded buffer", OFS_BUF_STATUS, 32'h0a2a);
    check("up buf pins", {26'h0, up_buf}, 32'h2a);
    check("down buf pins", {26'h0, down_buf}, 32'h0a);
    rdc("load cleared", OFS_CONTROL_0, 32'h88);
    // disable: pins fall to the inactive level, clock stops
    wr(OFS_CONTROL_0, 32'h08);
    repeat (3) @(posedge pclk);
    check("pins disabled", {28'h0, gate}, 32'h3);
    check("gen disabled", {31'h0, gen_enable}, 32'h0);
    cnt(0, 16);
    check("ticks disabled", 32'(c), 32'h0);
    results();
  end
endmodule
`default_nettype wire
